// ===== design/ciop_pkg.sv
// Constants shared by the configurable I/O port logic
package ciop_pkg;

  // Port indices inside the register block
  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_C = 3'h2;
  localparam logic [2:0] PORT_D = 3'h3;
  localparam logic [2:0] PORT_E = 3'h4;
  localparam logic [2:0] PORT_F = 3'h5;
  localparam logic [2:0] PORT_G = 3'h6;
  localparam logic [2:0] PORT_NONE = 3'h7;

  // Address layout: bit 7 clear, port in bits 6..4, register kind in 3..0
  localparam int ADDR_TOP_BIT = 7;
  localparam int ADDR_PORT_MSB = 6;
  localparam int ADDR_PORT_LSB = 4;
  localparam int ADDR_KIND_MSB = 3;

  // Register kinds within each port
  localparam logic [3:0] REG_PIN_INPUT_VALUE = 4'h0;
  localparam logic [3:0] REG_PIN_OUTPUT_LATCH = 4'h1;
  localparam logic [3:0] REG_PIN_DIRECTION = 4'h2;
  localparam logic [3:0] REG_PIN_DRIVE_SELECT = 4'h3;
  localparam logic [3:0] REG_PIN_MODE_SELECT = 4'h4;
  localparam logic [3:0] REG_OUTPUT_CELL_ACCESS = 4'h5;
  localparam logic [3:0] REG_OUTPUT_CELL_LOAD_MASK = 4'h6;
  localparam logic [3:0] REG_INPUT_CELL_VALUE = 4'h7;
  localparam logic [3:0] REG_DRIVER_ENABLE_STATE = 4'h8;

  // Memory-map configuration register and its buffer-mode bit
  localparam logic [7:0] ADDR_MEMORY_MAP_CONFIG = 8'h80;
  localparam int PERIPH_BUFFER_ENABLE_BIT = 7;

  // Reset values
  localparam logic [7:0] RESET_CONFIG = 8'h00;
  localparam logic [7:0] RESET_DATA = 8'h00;

  // Control-input port has four pins only
  localparam logic [7:0] CTRL_IN_PIN_MASK = 8'h0F;
  // Test port pins handed to in-circuit programming while it runs
  localparam logic [7:0] ISP_PIN_MASK = 8'h0F;

  localparam logic [7:0] ALL_ONES = 8'hFF;

endpackage : ciop_pkg

// ===== design/ciop_top.sv
// Configurable I/O port logic: registers, pin drivers and cell access
// Notes on behaviour
// RULE_01 - Memory-map config bit 7 enables buffer mode
// RULE_02 - Buffer mode: wide port bridges host bus
// RULE_03 - Buffer tri-stated unless a peripheral select active
// RULE_04 - Programming signals share test port pins
// RULE_05 - Registers reached by plain bus read/write
// RULE_06 - Register bit n serves pin n only
// RULE_07 - Mode, direction, drive reset to zero
// RULE_08 - Mode bit: 0 general I/O, 1 address
// RULE_09 - Mode register only on address ports
// RULE_10 - Direction bit 1 output, 0 input
// RULE_11 - Output-enable term ORed with direction bit
// RULE_12 - Control-input port uses four direction bits
// RULE_13 - Drive bit 1 gives open drain
// RULE_14 - Drive bit 1 gives fast slew elsewhere
// RULE_15 - Open drain or slew chosen per port
// RULE_16 - Pin input read returns pin level
// RULE_17 - Output latch drives pin when enabled
// RULE_18 - Output cell read/write with mask
// RULE_19 - Mask bit 1 blocks host cell loading
// RULE_20 - Input cells latch pins, feed array, readable
// RULE_21 - Enable-out read shows each driver state
// RULE_22 - Cell and enable registers on listed ports
// RULE_23 - Host sets enable or direction plus mode
// RULE_24 - Data-port mode disables wide port I/O
// RULE_25 - Writes reach pins at write cycle end
`timescale 1ns/10ps

module ciop_top (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // Host register bus
  input wire logic BUS_SEL,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [7:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  output logic [7:0] BUS_RDATA,
  output logic BUS_RDATA_OE,
  // Logic-array terms
  input wire logic [7:0] OE_TERM_A,
  input wire logic [7:0] OE_TERM_B,
  input wire logic [7:0] OE_TERM_C,
  input wire logic [7:0] OE_TERM_F,
  input wire logic [7:0] CHIPSEL_C,
  input wire logic [7:0] CHIPSEL_F,
  input wire logic PERIPH_SELECT_A,
  input wire logic PERIPH_SELECT_B,
  input wire logic NONMUX_DATA_MODE,
  // Output cells
  input wire logic [7:0] OUTPUT_CELL_D_A,
  input wire logic [7:0] OUTPUT_CELL_D_B,
  input wire logic OUTPUT_CELL_LOAD_A,
  input wire logic OUTPUT_CELL_LOAD_B,
  output logic [7:0] OUTPUT_CELL_A,
  output logic [7:0] OUTPUT_CELL_B,
  // Input cells
  input wire logic [7:0] INPUT_CELL_STROBE_A,
  input wire logic [7:0] INPUT_CELL_STROBE_B,
  input wire logic [7:0] INPUT_CELL_STROBE_C,
  output logic [7:0] INPUT_CELL_A,
  output logic [7:0] INPUT_CELL_B,
  output logic [7:0] INPUT_CELL_C,
  // Latched address for address output mode
  input wire logic [7:0] LATCHED_ADDR_E,
  input wire logic [7:0] LATCHED_ADDR_F,
  input wire logic [7:0] LATCHED_ADDR_G,
  // In-circuit programming on the test port
  input wire logic IN_CIRCUIT_PROGRAMMING,
  input wire logic [7:0] ISP_OUT,
  input wire logic [7:0] ISP_OE,
  // Port pins
  input wire logic [7:0] PORT_A_IN,
  output logic [7:0] PORT_A_OUT,
  output logic [7:0] PORT_A_OE,
  input wire logic [7:0] PORT_B_IN,
  output logic [7:0] PORT_B_OUT,
  output logic [7:0] PORT_B_OE,
  input wire logic [7:0] PORT_C_IN,
  output logic [7:0] PORT_C_OUT,
  output logic [7:0] PORT_C_OE,
  output logic [7:0] PORT_C_FAST_SLEW,
  input wire logic [3:0] PORT_D_IN,
  output logic [3:0] PORT_D_OUT,
  output logic [3:0] PORT_D_OE,
  input wire logic [7:0] PORT_E_IN,
  output logic [7:0] PORT_E_OUT,
  output logic [7:0] PORT_E_OE,
  input wire logic [7:0] PORT_F_IN,
  output logic [7:0] PORT_F_OUT,
  output logic [7:0] PORT_F_OE,
  output logic [7:0] PORT_F_FAST_SLEW,
  input wire logic [7:0] PORT_G_IN,
  output logic [7:0] PORT_G_OUT,
  output logic [7:0] PORT_G_OE
);

  typedef struct packed {
    logic [6:0][7:0] sync1;
    logic [6:0][7:0] sync2;
    logic [6:0][7:0] direction;
    logic [6:0][7:0] drive;
    logic [6:0][7:0] latch;
    logic [6:0][7:0] mode;
    logic [6:0][7:0] enable;
    logic [6:0][7:0] pin_out;
    logic [6:0][7:0] pin_oe;
    logic [1:0][7:0] cell_mask;
    logic [1:0][7:0] out_cell;
    logic [2:0][7:0] in_cell;
    logic [7:0] mem_map;
    logic [7:0] rdata;
    logic rdata_oe;
  } ciop_state_s;

  ciop_state_s state_reg;
  ciop_state_s state_next;
  logic [6:0][7:0] pin_raw;

  // Open-drain shaping: drive only lows, release highs to the pull-up
  function automatic logic [15:0] ciop_shape(input logic [7:0] en,
                                             input logic [7:0] val,
                                             input logic [7:0] od);
    logic [7:0] oe;
    logic [7:0] out;
    oe = en & (~od | ~val);
    out = val & ~od;
    return {oe, out};
  endfunction : ciop_shape

  // Whether a register kind exists on a given port
  function automatic logic ciop_exists(input logic [2:0] port,
                                       input logic [3:0] kind);
    logic ok;
    ok = 1'b0;
    case (kind)
      ciop_pkg::REG_PIN_INPUT_VALUE,
      ciop_pkg::REG_PIN_OUTPUT_LATCH,
      ciop_pkg::REG_PIN_DIRECTION,
      ciop_pkg::REG_PIN_DRIVE_SELECT: ok = 1'b1;
      ciop_pkg::REG_PIN_MODE_SELECT: ok = (port >= ciop_pkg::PORT_E);
      ciop_pkg::REG_OUTPUT_CELL_ACCESS,
      ciop_pkg::REG_OUTPUT_CELL_LOAD_MASK:
        ok = (port <= ciop_pkg::PORT_B);
      ciop_pkg::REG_INPUT_CELL_VALUE: ok = (port <= ciop_pkg::PORT_C);
      ciop_pkg::REG_DRIVER_ENABLE_STATE:
        ok = (port <= ciop_pkg::PORT_C) || (port == ciop_pkg::PORT_F);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : ciop_exists

  assign pin_raw[ciop_pkg::PORT_A] = PORT_A_IN;
  assign pin_raw[ciop_pkg::PORT_B] = PORT_B_IN;
  assign pin_raw[ciop_pkg::PORT_C] = PORT_C_IN;
  assign pin_raw[ciop_pkg::PORT_D] = {4'h0, PORT_D_IN};
  assign pin_raw[ciop_pkg::PORT_E] = PORT_E_IN;
  assign pin_raw[ciop_pkg::PORT_F] = PORT_F_IN;
  assign pin_raw[ciop_pkg::PORT_G] = PORT_G_IN;

  always_comb begin
    logic [2:0] port;
    logic [3:0] kind;
    logic in_block;
    logic host_wr;
    logic host_rd;
    logic periph_on;
    logic periph_sel;
    logic [7:0] wmask;
    logic [6:0][7:0] val;
    logic [15:0] shaped;
    state_next = state_reg;
    port = BUS_ADDR[ciop_pkg::ADDR_PORT_MSB:ciop_pkg::ADDR_PORT_LSB];
    kind = BUS_ADDR[ciop_pkg::ADDR_KIND_MSB:0];
    in_block = !BUS_ADDR[ciop_pkg::ADDR_TOP_BIT] &&
               (port != ciop_pkg::PORT_NONE) && ciop_exists(port, kind);
    host_wr = BUS_SEL && BUS_WR;
    host_rd = BUS_SEL && BUS_RD;
    wmask = (port == ciop_pkg::PORT_D) ? ciop_pkg::CTRL_IN_PIN_MASK :
            ciop_pkg::ALL_ONES; // RULE_12
    val = state_reg.latch;
    shaped = 16'h0000;
    periph_on = 1'b0;
    periph_sel = PERIPH_SELECT_A || PERIPH_SELECT_B;

    // Pins cross into the clock domain through two flip-flops
    state_next.sync1 = pin_raw;
    state_next.sync2 = state_reg.sync1;

    // Register writes
    if (host_wr && in_block) begin // RULE_05
      case (kind)
        ciop_pkg::REG_PIN_OUTPUT_LATCH:
          state_next.latch[port] = BUS_WDATA & wmask; // RULE_17
        ciop_pkg::REG_PIN_DIRECTION:
          state_next.direction[port] = BUS_WDATA & wmask; // RULE_10
        ciop_pkg::REG_PIN_DRIVE_SELECT:
          state_next.drive[port] = BUS_WDATA & wmask; // RULE_13
        ciop_pkg::REG_PIN_MODE_SELECT:
          state_next.mode[port] = BUS_WDATA; // RULE_09
        ciop_pkg::REG_OUTPUT_CELL_LOAD_MASK:
          state_next.cell_mask[port[0]] = BUS_WDATA; // RULE_19
        default: ;
      endcase
    end
    if (host_wr && (BUS_ADDR == ciop_pkg::ADDR_MEMORY_MAP_CONFIG)) begin
      state_next.mem_map = BUS_WDATA;
    end

    // Output cells: array loads first, host write overrides unmasked bits
    for (int p = 0; p < 2; p++) begin
      if ((p == 0) ? OUTPUT_CELL_LOAD_A : OUTPUT_CELL_LOAD_B) begin
        state_next.out_cell[p] = (p == 0) ? OUTPUT_CELL_D_A :
                                 OUTPUT_CELL_D_B;
      end
      if (host_wr && in_block && (port == 3'(p)) &&
          (kind == ciop_pkg::REG_OUTPUT_CELL_ACCESS)) begin
        state_next.out_cell[p] =
          (state_next.out_cell[p] & state_reg.cell_mask[p]) |
          (BUS_WDATA & ~state_reg.cell_mask[p]); // RULE_18 RULE_19
      end
    end

    // Input cells capture the synchronised pin on their strobe
    for (int b = 0; b < 8; b++) begin
      if (INPUT_CELL_STROBE_A[b]) begin
        state_next.in_cell[0][b] = state_reg.sync2[ciop_pkg::PORT_A][b];
      end
      if (INPUT_CELL_STROBE_B[b]) begin
        state_next.in_cell[1][b] = state_reg.sync2[ciop_pkg::PORT_B][b];
      end
      if (INPUT_CELL_STROBE_C[b]) begin // RULE_20
        state_next.in_cell[2][b] = state_reg.sync2[ciop_pkg::PORT_C][b];
      end
    end

    // Driver enables from the new register values, so a write lands on
    // the pins at the same edge that stores it
    state_next.enable[ciop_pkg::PORT_A] =
      state_next.direction[ciop_pkg::PORT_A] | OE_TERM_A; // RULE_11
    state_next.enable[ciop_pkg::PORT_B] =
      state_next.direction[ciop_pkg::PORT_B] | OE_TERM_B; // RULE_11
    state_next.enable[ciop_pkg::PORT_C] =
      state_next.direction[ciop_pkg::PORT_C] | OE_TERM_C; // RULE_11
    state_next.enable[ciop_pkg::PORT_D] =
      state_next.direction[ciop_pkg::PORT_D] &
      ciop_pkg::CTRL_IN_PIN_MASK; // RULE_12
    state_next.enable[ciop_pkg::PORT_E] =
      state_next.direction[ciop_pkg::PORT_E]; // RULE_10
    state_next.enable[ciop_pkg::PORT_G] =
      state_next.direction[ciop_pkg::PORT_G]; // RULE_10

    // Pin values: logic-array output where its term drives, else latch
    val = state_next.latch; // RULE_06 RULE_17 RULE_25
    for (int b = 0; b < 8; b++) begin
      if (OE_TERM_A[b]) begin
        val[ciop_pkg::PORT_A][b] = state_next.out_cell[0][b];
      end
      if (OE_TERM_B[b]) begin
        val[ciop_pkg::PORT_B][b] = state_next.out_cell[1][b];
      end
      if (OE_TERM_C[b]) begin
        val[ciop_pkg::PORT_C][b] = CHIPSEL_C[b];
      end
      if (OE_TERM_F[b]) begin
        val[ciop_pkg::PORT_F][b] = CHIPSEL_F[b];
      end
      // Address output is chosen per pin by the mode bit
      if (state_next.mode[ciop_pkg::PORT_E][b]) begin // RULE_08 RULE_23
        val[ciop_pkg::PORT_E][b] = LATCHED_ADDR_E[b];
      end
      if (state_next.mode[ciop_pkg::PORT_F][b]) begin // RULE_08 RULE_23
        val[ciop_pkg::PORT_F][b] = LATCHED_ADDR_F[b];
      end
      if (state_next.mode[ciop_pkg::PORT_G][b]) begin // RULE_08 RULE_23
        val[ciop_pkg::PORT_G][b] = LATCHED_ADDR_G[b];
      end
    end

    // Wide data port: data-port mode, buffer mode, or general I/O
    periph_on = state_next.mem_map[ciop_pkg::PERIPH_BUFFER_ENABLE_BIT];
    if (NONMUX_DATA_MODE) begin
      state_next.enable[ciop_pkg::PORT_F] = 8'h00; // RULE_24
    end else if (periph_on) begin // RULE_01
      // Host write drives the peripheral; otherwise released
      state_next.enable[ciop_pkg::PORT_F] =
        (periph_sel && BUS_WR) ? ciop_pkg::ALL_ONES : 8'h00; // RULE_03
      val[ciop_pkg::PORT_F] = BUS_WDATA; // RULE_02
    end else begin
      state_next.enable[ciop_pkg::PORT_F] =
        state_next.direction[ciop_pkg::PORT_F] | OE_TERM_F; // RULE_11
    end

    // Every port shaped open drain where its drive bit is 1; C and F then revert to push-pull
    for (int p = 0; p < 7; p++) begin
      shaped = ciop_shape(state_next.enable[p], val[p],
                          state_next.drive[p]); // RULE_15
      {state_next.pin_oe[p], state_next.pin_out[p]} = shaped; // RULE_13
    end
    state_next.pin_oe[ciop_pkg::PORT_C] =
      state_next.enable[ciop_pkg::PORT_C]; // RULE_14
    state_next.pin_out[ciop_pkg::PORT_C] = val[ciop_pkg::PORT_C];
    state_next.pin_oe[ciop_pkg::PORT_F] =
      state_next.enable[ciop_pkg::PORT_F]; // RULE_14
    state_next.pin_out[ciop_pkg::PORT_F] = val[ciop_pkg::PORT_F];

    // Programming takes over the shared test port pins; never used in
    // normal operation, so no arbitration with general I/O is needed
    if (IN_CIRCUIT_PROGRAMMING) begin // RULE_04
      for (int b = 0; b < 8; b++) begin
        if (ciop_pkg::ISP_PIN_MASK[b]) begin
          state_next.pin_oe[ciop_pkg::PORT_E][b] = ISP_OE[b];
          state_next.pin_out[ciop_pkg::PORT_E][b] = ISP_OUT[b];
        end
      end
    end

    // Read path: register read first, then the buffer-mode read
    state_next.rdata = 8'h00;
    state_next.rdata_oe = 1'b0;
    if (host_rd) begin // RULE_05
      state_next.rdata_oe = 1'b1;
      if (BUS_ADDR == ciop_pkg::ADDR_MEMORY_MAP_CONFIG) begin
        state_next.rdata = state_reg.mem_map;
      end else if (in_block) begin
        case (kind)
          ciop_pkg::REG_PIN_INPUT_VALUE:
            state_next.rdata = state_reg.sync2[port]; // RULE_16
          ciop_pkg::REG_PIN_OUTPUT_LATCH:
            state_next.rdata = state_reg.latch[port]; // RULE_17
          ciop_pkg::REG_PIN_DIRECTION:
            state_next.rdata = state_reg.direction[port];
          ciop_pkg::REG_PIN_DRIVE_SELECT:
            state_next.rdata = state_reg.drive[port];
          ciop_pkg::REG_PIN_MODE_SELECT:
            state_next.rdata = state_reg.mode[port];
          ciop_pkg::REG_OUTPUT_CELL_ACCESS:
            state_next.rdata = state_reg.out_cell[port[0]]; // RULE_18
          ciop_pkg::REG_OUTPUT_CELL_LOAD_MASK:
            state_next.rdata = state_reg.cell_mask[port[0]];
          ciop_pkg::REG_INPUT_CELL_VALUE:
            state_next.rdata = state_reg.in_cell[port[1:0]]; // RULE_20
          ciop_pkg::REG_DRIVER_ENABLE_STATE:
            state_next.rdata = state_reg.enable[port]; // RULE_21 RULE_22
          default: state_next.rdata = 8'h00;
        endcase
      end
    end else if (periph_on && periph_sel && BUS_RD &&
                 !NONMUX_DATA_MODE) begin
      // Peripheral read: pins reach the host through the synchroniser
      state_next.rdata = state_reg.sync2[ciop_pkg::PORT_F]; // RULE_02
      state_next.rdata_oe = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= '0; // RULE_07
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state flip-flops
  assign BUS_RDATA = state_reg.rdata;
  assign BUS_RDATA_OE = state_reg.rdata_oe;
  assign OUTPUT_CELL_A = state_reg.out_cell[0];
  assign OUTPUT_CELL_B = state_reg.out_cell[1];
  assign INPUT_CELL_A = state_reg.in_cell[0];
  assign INPUT_CELL_B = state_reg.in_cell[1];
  assign INPUT_CELL_C = state_reg.in_cell[2];
  assign PORT_A_OUT = state_reg.pin_out[ciop_pkg::PORT_A];
  assign PORT_A_OE = state_reg.pin_oe[ciop_pkg::PORT_A];
  assign PORT_B_OUT = state_reg.pin_out[ciop_pkg::PORT_B];
  assign PORT_B_OE = state_reg.pin_oe[ciop_pkg::PORT_B];
  assign PORT_C_OUT = state_reg.pin_out[ciop_pkg::PORT_C];
  assign PORT_C_OE = state_reg.pin_oe[ciop_pkg::PORT_C];
  assign PORT_C_FAST_SLEW = state_reg.drive[ciop_pkg::PORT_C]; // RULE_14
  assign PORT_D_OUT = state_reg.pin_out[ciop_pkg::PORT_D][3:0];
  assign PORT_D_OE = state_reg.pin_oe[ciop_pkg::PORT_D][3:0];
  assign PORT_E_OUT = state_reg.pin_out[ciop_pkg::PORT_E];
  assign PORT_E_OE = state_reg.pin_oe[ciop_pkg::PORT_E];
  assign PORT_F_OUT = state_reg.pin_out[ciop_pkg::PORT_F];
  assign PORT_F_OE = state_reg.pin_oe[ciop_pkg::PORT_F];
  assign PORT_F_FAST_SLEW = state_reg.drive[ciop_pkg::PORT_F]; // RULE_14
  assign PORT_G_OUT = state_reg.pin_out[ciop_pkg::PORT_G];
  assign PORT_G_OE = state_reg.pin_oe[ciop_pkg::PORT_G];

endmodule : ciop_top

// ===== verification/ciop_checker.sv
// Port-level checker of the configurable I/O port logic
`timescale 1ns/10ps

module ciop_checker (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // Host bus
  input wire logic BUS_SEL,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [7:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  input wire logic [7:0] BUS_RDATA,
  input wire logic BUS_RDATA_OE,
  // Array terms and controls
  input wire logic [7:0] OE_TERM_C,
  input wire logic [7:0] CHIPSEL_C,
  input wire logic PERIPH_SELECT_A,
  input wire logic PERIPH_SELECT_B,
  input wire logic NONMUX_DATA_MODE,
  input wire logic OUTPUT_CELL_LOAD_A,
  input wire logic [7:0] OUTPUT_CELL_A,
  input wire logic IN_CIRCUIT_PROGRAMMING,
  input wire logic [7:0] ISP_OUT,
  input wire logic [7:0] ISP_OE,
  // Pins
  input wire logic [7:0] PORT_C_OUT,
  input wire logic [7:0] PORT_C_OE,
  input wire logic [7:0] PORT_C_FAST_SLEW,
  input wire logic [7:0] PORT_E_OUT,
  input wire logic [7:0] PORT_E_OE,
  input wire logic [7:0] PORT_F_OUT,
  input wire logic [7:0] PORT_F_OE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  // Shadows of buffer-mode bit and cell mask, rebuilt from bus writes
  logic buf_on_reg, buf_on_next;
  logic [7:0] mask_reg, mask_next;
  wire wr_c = BUS_SEL && BUS_WR;
  wire cfg_wr = wr_c && BUS_ADDR == 8'h80;
  always_comb begin
    buf_on_next = cfg_wr ? BUS_WDATA[7] : buf_on_reg;
    mask_next = (wr_c && BUS_ADDR == 8'h06) ? BUS_WDATA : mask_reg;
  end
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      buf_on_reg <= 1'b0;
      mask_reg <= 8'h00;
    end else begin
      buf_on_reg <= buf_on_next;
      mask_reg <= mask_next;
    end
  end
  sequence s_buf_live;
    buf_on_reg && !NONMUX_DATA_MODE && !cfg_wr;
  endsequence
  sequence s_buf_sel;
    s_buf_live ##0 (PERIPH_SELECT_A || PERIPH_SELECT_B);
  endsequence
  property p_read_answer;
    BUS_SEL && BUS_RD |=> BUS_RDATA_OE;
  endproperty
  property p_idle_quiet;
    !BUS_RD |=> !BUS_RDATA_OE && BUS_RDATA == 8'h00;
  endproperty
  property p_dir_c;
    wr_c && BUS_ADDR == 8'h22 |=>
      PORT_C_OE == ($past(BUS_WDATA) | $past(OE_TERM_C));
  endproperty
  property p_term_c;
    RESETN |=> ((PORT_C_OUT ^ $past(CHIPSEL_C)) & $past(OE_TERM_C)) == 8'h00;
  endproperty
  property p_slew_c;
    wr_c && BUS_ADDR == 8'h23 |=> PORT_C_FAST_SLEW == $past(BUS_WDATA);
  endproperty
  property p_buf_drive;
    s_buf_sel ##0 BUS_WR |=>
      PORT_F_OE == 8'hFF && PORT_F_OUT == $past(BUS_WDATA);
  endproperty
  property p_buf_off;
    s_buf_live ##0 !(PERIPH_SELECT_A || PERIPH_SELECT_B) |=>
      PORT_F_OE == 8'h00;
  endproperty
  property p_nonmux;
    NONMUX_DATA_MODE [*2] |-> PORT_F_OE == 8'h00;
  endproperty
  property p_isp;
    IN_CIRCUIT_PROGRAMMING |=> ((PORT_E_OE ^ $past(ISP_OE)) & 8'h0F) == 8'h00
      && ((PORT_E_OUT ^ $past(ISP_OUT)) & 8'h0F) == 8'h00;
  endproperty
  property p_cell;
    wr_c && BUS_ADDR == 8'h05 && !OUTPUT_CELL_LOAD_A |=> OUTPUT_CELL_A ==
      (($past(BUS_WDATA) & ~mask_reg) | ($past(OUTPUT_CELL_A) & mask_reg));
  endproperty
  property p_reset;
    disable iff (1'b0) !RESETN ##1 !RESETN |-> PORT_C_OE == 8'h00
      && PORT_F_OE == 8'h00 && !BUS_RDATA_OE;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered");
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("read data without read");
  a_dir_c: assert property (p_dir_c)
    else $error("direction write not on pins");
  a_term_c: assert property (p_term_c)
    else $error("array value not on enabled pin");
  a_slew_c: assert property (p_slew_c)
    else $error("slew select not applied");
  a_buf_drive: assert property (p_buf_drive)
    else $error("buffer write not driven");
  a_buf_off: assert property (p_buf_off)
    else $error("buffer not released");
  a_nonmux: assert property (p_nonmux)
    else $error("data-bus port still driven");
  a_isp: assert property (p_isp)
    else $error("programming pins not handed over");
  a_cell: assert property (p_cell)
    else $error("cell load ignores mask");
  a_reset: assert property (p_reset)
    else $error("driver active in reset");
endmodule : ciop_checker

bind ciop_top ciop_checker ciop_checker_i (.CLOCK(CLOCK), .RESETN(RESETN),
  .BUS_SEL(BUS_SEL), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_ADDR(BUS_ADDR),
  .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA), .BUS_RDATA_OE(BUS_RDATA_OE),
  .OE_TERM_C(OE_TERM_C), .CHIPSEL_C(CHIPSEL_C),
  .PERIPH_SELECT_A(PERIPH_SELECT_A), .PERIPH_SELECT_B(PERIPH_SELECT_B),
  .NONMUX_DATA_MODE(NONMUX_DATA_MODE), .OUTPUT_CELL_A(OUTPUT_CELL_A),
  .OUTPUT_CELL_LOAD_A(OUTPUT_CELL_LOAD_A), .ISP_OUT(ISP_OUT), .ISP_OE(ISP_OE),
  .IN_CIRCUIT_PROGRAMMING(IN_CIRCUIT_PROGRAMMING), .PORT_C_OUT(PORT_C_OUT),
  .PORT_C_OE(PORT_C_OE), .PORT_C_FAST_SLEW(PORT_C_FAST_SLEW),
  .PORT_E_OUT(PORT_E_OUT), .PORT_E_OE(PORT_E_OE), .PORT_F_OUT(PORT_F_OUT),
  .PORT_F_OE(PORT_F_OE));

// ===== verification/ciop_partner.sv
// Far-side model: level of each pin of one port
`timescale 1ns/10ps

module ciop_partner #(parameter int W = 8) (
  // Device side
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] out,
  // Outside world, the device on the far side of this port
  input wire logic [W-1:0] ext,
  output logic [W-1:0] pin
);
  // Released pins show the outside level, never the last driven value
  always_comb pin = (oe & out) | (~oe & ext);
endmodule : ciop_partner

// ===== verification/ciop_top_bench.sv
// Self-checking bench of the configurable I/O port logic
`timescale 1ns/10ps

module ciop_top_bench;
  logic clk, rst_n, sel, wr, rd, psa, psb, nonmux, in_circuit_programming, ld_a, rdata_oe;
  logic [7:0] addr, wdata, rdata, term_a, term_c, term_f, cs_c, d_a, stb_c;
  logic [7:0] isp_out, isp_oe, lat_e, ext_a, ext_c, ext_f, pin_b, pin_e;
  logic [7:0] pin_g, a_in, a_out, a_oe, c_in, c_out, c_oe, c_slew, f_in;
  logic [7:0] f_out, f_oe, e_out, e_oe, g_out, g_oe, oc_a, ic_c;
  logic [3:0] pin_d, d_oe;
  int n_errors = 0;
  int checks_done = 0;
  logic [7:0] rst_addr [11] = '{8'h02, 8'h03, 8'h12, 8'h13, 8'h22, 8'h32,
    8'h44, 8'h54, 8'h64, 8'h06, 8'h16};
  ciop_top ciop_top_i (.CLOCK(clk), .RESETN(rst_n), .BUS_SEL(sel),
    .BUS_WR(wr), .BUS_RD(rd), .BUS_ADDR(addr), .BUS_WDATA(wdata),
    .BUS_RDATA(rdata), .BUS_RDATA_OE(rdata_oe), .OE_TERM_A(term_a),
    .OE_TERM_B(term_a), .OE_TERM_C(term_c), .OE_TERM_F(term_f),
    .CHIPSEL_C(cs_c), .CHIPSEL_F(cs_c), .PERIPH_SELECT_A(psa),
    .PERIPH_SELECT_B(psb), .NONMUX_DATA_MODE(nonmux), .OUTPUT_CELL_D_A(d_a),
    .OUTPUT_CELL_D_B(d_a), .OUTPUT_CELL_LOAD_A(ld_a),
    .OUTPUT_CELL_LOAD_B(ld_a), .OUTPUT_CELL_A(oc_a), .OUTPUT_CELL_B(),
    .INPUT_CELL_STROBE_A(stb_c), .INPUT_CELL_STROBE_B(stb_c),
    .INPUT_CELL_STROBE_C(stb_c), .INPUT_CELL_A(), .INPUT_CELL_B(),
    .INPUT_CELL_C(ic_c), .LATCHED_ADDR_E(lat_e),
    .LATCHED_ADDR_F(lat_e), .LATCHED_ADDR_G(lat_e),
    .IN_CIRCUIT_PROGRAMMING(in_circuit_programming), .ISP_OUT(isp_out), .ISP_OE(isp_oe),
    .PORT_A_IN(a_in), .PORT_A_OUT(a_out), .PORT_A_OE(a_oe),
    .PORT_B_IN(pin_b), .PORT_B_OUT(), .PORT_B_OE(), .PORT_C_IN(c_in),
    .PORT_C_OUT(c_out), .PORT_C_OE(c_oe), .PORT_C_FAST_SLEW(c_slew),
    .PORT_D_IN(pin_d), .PORT_D_OUT(), .PORT_D_OE(d_oe), .PORT_E_IN(pin_e),
    .PORT_E_OUT(e_out), .PORT_E_OE(e_oe), .PORT_F_IN(f_in), .PORT_F_OUT(f_out),
    .PORT_F_OE(f_oe), .PORT_F_FAST_SLEW(), .PORT_G_IN(pin_g),
    .PORT_G_OUT(g_out), .PORT_G_OE(g_oe));
  ciop_partner #(.W(8)) ciop_partner_i (.oe(f_oe), .out(f_out), .ext(ext_f),
    .pin(f_in));
  ciop_partner #(.W(8)) ciop_partner_a_i (.oe(a_oe), .out(a_out),
    .ext(ext_a), .pin(a_in));
  ciop_partner #(.W(8)) ciop_partner_c_i (.oe(c_oe), .out(c_out),
    .ext(ext_c), .pin(c_in));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One idle cycle between requests keeps each strobe a single write
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {sel, wr, addr, wdata} <= {2'b11, a, d};
    @(posedge clk);
    {sel, wr} <= 2'b00;
    #1;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    {sel, rd, addr} <= {2'b11, a};
    @(posedge clk);
    {sel, rd} <= 2'b00;
    #1 chk(rdata, exp);
  endtask : rreg

  task automatic test_done;
    $display("counts: %0d checks, %0d mismatches", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  initial begin
    {sel, wr, rd, psa, psb, nonmux, in_circuit_programming, ld_a, rst_n} = '0;
    {addr, wdata, term_a, term_c, term_f, cs_c, d_a, stb_c} = '0;
    {isp_out, isp_oe, ext_a, pin_b, pin_e, pin_g, ext_f, pin_d} = '0;
    lat_e = 8'h96;
    ext_c = 8'h0F;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rst_addr[i]) rreg(rst_addr[i], 8'h00);
    $display("test reset done");
    wreg(8'h22, 8'h5A);
    wreg(8'h23, 8'hA5);
    wreg(8'h21, 8'h3C);
    chk(c_oe, 8'h5A);
    chk(c_slew, 8'hA5);
    chk(c_out & c_oe, 8'h18);
    rreg(8'h21, 8'h3C);
    rreg(8'h20, 8'h1D);
    {term_c, cs_c} <= {8'h81, 8'h01};
    rreg(8'h28, 8'hDB);
    stb_c <= 8'hFF;
    @(posedge clk);
    stb_c <= 8'h00;
    rreg(8'h27, 8'h1D);
    chk(ic_c, 8'h1D);
    $display("test port C done");
    wreg(8'h32, 8'hFF);
    rreg(8'h32, 8'h0F);
    chk({4'h0, d_oe}, 8'h0F);
    wreg(8'h14, 8'hFF);
    rreg(8'h14, 8'h00);
    wreg(8'h44, 8'hFF);
    wreg(8'h42, 8'hFF);
    chk(e_out, 8'h96);
    wreg(8'h62, 8'hFF);
    wreg(8'h63, 8'hFF);
    wreg(8'h61, 8'h0F);
    chk(g_oe, 8'hF0);
    chk(g_out, 8'h00);
    term_a <= 8'h30;
    wreg(8'h02, 8'h03);
    rreg(8'h08, 8'h33);
    wreg(8'h06, 8'hF0);
    wreg(8'h05, 8'hFF);
    rreg(8'h05, 8'h0F);
    chk(oc_a, 8'h0F);
    $display("test config done");
    wreg(8'h80, 8'h80);
    {psa, wr, wdata} <= {2'b11, 8'hC3};
    @(posedge clk);
    wr <= 1'b0;
    #1 chk(f_oe, 8'hFF);
    chk(f_out, 8'hC3);
    @(posedge clk);
    {psa, psb, rd, ext_f} <= {3'b011, 8'h6E};
    repeat (4) @(posedge clk);
    #1 chk(f_oe, 8'h00);
    chk(rdata, 8'h6E);
    @(posedge clk);
    {psb, rd, psa, wr, nonmux} <= 5'b00111;
    repeat (2) @(posedge clk);
    #1 chk(f_oe, 8'h00);
    @(posedge clk);
    {psa, wr, nonmux, in_circuit_programming, isp_oe, isp_out} <= {4'b0001, 8'h0F, 8'h05};
    @(posedge clk);
    #1 chk(e_oe & 8'h0F, 8'h0F);
    chk(e_out & 8'h0F, 8'h05);
    $display("test buffer done");
    test_done();
  end

  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    test_done();
  end
endmodule : ciop_top_bench
